// ===== pkg/ifd_pkg.sv
/*
  Shared constants for the instruction field and flag decoder: register
  offsets and reset values, instruction field positions (bit 0 is the
  most significant bit of the word), opcodes and extended-opcode forms.
  Assumes a 32-bit instruction word and a 64-bit datapath.
*/
package ifd_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_XER  = 8'h04;
  localparam logic [7:0] ADDR_CR   = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;

  // Control register fields and reset value
  localparam int         CTRL_MODE32_BIT = 0;
  localparam int         CTRL_IMPL64_BIT = 1;
  localparam logic [1:0] CTRL_RST        = 2'h2;

  // Fixed exception register fields and reset value
  localparam int         XER_CA_BIT = 0;
  localparam int         XER_OV_BIT = 1;
  localparam int         XER_SO_BIT = 2;
  localparam logic [2:0] XER_RST    = 3'h0;

  // Condition fields: integer field high nibble, float field low nibble
  localparam logic [7:0] CR_RST = 8'h00;

  // Field positions, big-endian numbering
  localparam int PRIMARY_OPCODE_FIRST = 0;
  localparam int PRIMARY_OPCODE_LAST  = 5;
  localparam int TO_FIRST   = 6;
  localparam int TO_LAST    = 10;
  localparam int RA_FIRST   = 11;
  localparam int RA_LAST    = 15;
  localparam int IMM_FIRST  = 16;
  localparam int IMM_LAST   = 31;
  localparam int LI_FIRST   = 6;
  localparam int LI_LAST    = 29;
  localparam int AA_BIT     = 30;
  localparam int OE_BIT     = 21;
  localparam int RC_BIT     = 31;

  // Primary opcodes; OP_CROPS, OP_EXT, OP_ROT64, OP_DSLD, OP_DSST and OP_FP select a form
  localparam logic [5:0] OP_TWI    = 6'h03;
  localparam logic [5:0] OP_CMPLI  = 6'h0A;
  localparam logic [5:0] OP_CMPI   = 6'h0B;
  localparam logic [5:0] OP_ADDI   = 6'h0E;
  localparam logic [5:0] OP_BRANCH = 6'h12;
  localparam logic [5:0] OP_CROPS  = 6'h13;
  localparam logic [5:0] OP_ORI    = 6'h18;
  localparam logic [5:0] OP_ANDI   = 6'h1C;
  localparam logic [5:0] OP_ROT64  = 6'h1E;
  localparam logic [5:0] OP_EXT    = 6'h1F;
  localparam logic [5:0] OP_DSLD   = 6'h3A;
  localparam logic [5:0] OP_DSST   = 6'h3E;
  localparam logic [5:0] OP_FP     = 6'h3F;

  // Extended opcodes: arithmetic group (bits 22-30), shift immediate (bits 21-29), trap (bits 21-30)
  localparam logic [8:0] XO_ADD   = 9'h10A;
  localparam logic [8:0] XO_ADDC  = 9'h00A;
  localparam logic [8:0] XO_ADDE  = 9'h08A;
  localparam logic [8:0] XO_SUBF  = 9'h028;
  localparam logic [8:0] XO_SUBFC = 9'h008;
  localparam logic [8:0] XO_SUBFE = 9'h088;
  localparam logic [8:0] XO_NEG   = 9'h068;
  localparam logic [8:0] XO_SRADI = 9'h19D;
  localparam logic [9:0] XO_TW    = 10'h004;

  // Sequential fetch step in bytes
  localparam logic [63:0] INSN_STEP = 64'h0000_0000_0000_0004;

  // Where the extended opcode sits
  typedef enum logic [2:0] {
    XO_NONE, XO_21_29, XO_21_30, XO_22_30,
    XO_26_30, XO_27_29, XO_27_30, XO_30_31
  } ifd_xo_form_t;

endpackage

// ===== rtl/ifd_alu.sv
/*
  Two's-complement adder with carry in and out, signed overflow and
  separate signed and unsigned compare of its two operands.
  Purely combinational; the caller registers what it keeps.
*/
`timescale 1ns/100ps
module ifd_alu (
  // Operands
  input  wire logic [63:0] a_in,
  input  wire logic [63:0] b_in,
  input  wire logic        cin_in,
  input  wire logic        mode32_in,
  // Results
  output logic [63:0]      sum_out,
  output logic             cout_out,
  output logic             ovf_out,
  output logic             lt_s_out,
  output logic             lt_u_out,
  output logic             eq_out
);

  logic [64:0] wide;    // Full 64-bit sum with carry
  logic [32:0] low;     // Low word sum, carry for 32-bit mode
  logic [63:0] sum;     // Sum bits only

  // Adder and compare
  always_comb begin
    wide    = {1'b0, a_in} + {1'b0, b_in} + {64'h0, cin_in};
    low     = {1'b0, a_in[31:0]} + {1'b0, b_in[31:0]} + {32'h0, cin_in};
    sum     = wide[63:0];
    sum_out = sum;
    if (mode32_in) begin
      // Narrow mode looks only at the low word
      cout_out = low[32];
      ovf_out  = (a_in[31] == b_in[31]) && (sum[31] != a_in[31]);
      lt_s_out = $signed(a_in[31:0]) < $signed(b_in[31:0]);
      lt_u_out = a_in[31:0] < b_in[31:0];
      eq_out   = a_in[31:0] == b_in[31:0];
    end else begin
      cout_out = wide[64];
      ovf_out  = (a_in[63] == b_in[63]) && (sum[63] != a_in[63]);
      lt_s_out = $signed(a_in) < $signed(b_in);
      lt_u_out = a_in < b_in;
      eq_out   = a_in == b_in;
    end
  end

endmodule

// ===== rtl/ifd_decode.sv
/*
  Instruction field and flag decoder. Takes one instruction a cycle from
  fetch with its address and operand register contents, registers the
  decoded fields, the integer result, the flag and condition updates and
  the next fetch address. Control and flags sit behind an APB slave.
  Assumes operand contents arrive in the same cycle as the instruction.
*/
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module ifd_decode (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        arst_n_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Fetch stage and operand contents
  input  wire logic        insn_valid_in,
  input  wire logic [31:0] insn_in,
  input  wire logic [63:0] cia_in,
  input  wire logic [63:0] gpr_a_data_in,
  input  wire logic [63:0] gpr_b_data_in,
  input  wire logic [63:0] gpr_s_data_in,
  // Decoded fields
  output logic [4:0]       trap_cond_out,
  output logic             trap_en_out,
  output logic [63:0]      unsigned_immediate_ext_out,
  output logic [9:0]       xo_out,
  output logic [2:0]       xo_form_out,
  output logic             illegal_out,
  // Writeback and fetch redirect
  output logic [63:0]      result_out,
  output logic             gpr_wr_en_out,
  output logic [4:0]       gpr_wr_sel_out,
  output logic [63:0]      next_fetch_out,
  output logic             fetch_valid_out,
  // Architected flags
  output logic [7:0]       cond_reg_out,
  output logic             carry_flag_out,
  output logic             overflow_flag_out,
  output logic             summary_ovf_out
);

  // Field of the word by big-endian positions
  function automatic logic [31:0] be_field(input logic [31:0] w,
                                           input int first, input int last);
    logic [31:0] sh;
    sh = w >> (31 - last);
    return sh & ((32'h1 << (last - first + 1)) - 32'h1);
  endfunction

  // Registered state
  logic [4:0]  trap_cond_ff, nxt_trap_cond;
  logic        trap_en_ff, nxt_trap_en;
  logic [63:0] unsigned_immediate_ext_ff, nxt_unsigned_immediate_ext;
  logic [9:0]  xo_ff, nxt_xo;
  logic [2:0]  xo_form_ff, nxt_xo_form;
  logic        illegal_ff, nxt_illegal;
  logic [63:0] result_ff, nxt_result;
  logic        wr_en_ff, nxt_wr_en;
  logic [4:0]  wr_sel_ff, nxt_wr_sel;
  logic [63:0] fetch_ff, nxt_fetch;
  logic        fvalid_ff, nxt_fvalid;
  logic [7:0]  cr_ff, nxt_cr;
  logic [2:0]  xer_ff, nxt_xer;
  logic [15:0] ill_cnt_ff, nxt_ill_cnt;
  logic [1:0]  ctrl_ff, nxt_ctrl;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready;
  logic        pslverr_ff, nxt_pslverr;

  // Decode wires
  ifd_pkg::ifd_xo_form_t form;   // Extended opcode position
  logic [5:0]  primary_opcode;             // Primary opcode
  logic [4:0]  base_sel;         // Base register number
  logic [4:0]  targ_sel;         // Target register number
  logic [8:0]  xo9;              // Arithmetic extended opcode
  logic [15:0] imm16;            // Immediate bits
  logic [63:0] unsigned_immediate_ext;         // Zero-extended immediate
  logic [63:0] simm_ext;         // Sign-extended immediate
  logic [63:0] base_val;         // Base register or zero
  logic [63:0] tgt;              // Branch target before masking
  logic        mode32;           // Narrow addressing in force
  logic        impl64;           // Wide implementation
  logic        arith;            // Arithmetic group member
  logic        oe;               // Overflow enable bit
  logic        rc;               // Record bit
  logic        exec;             // Legal valid instruction
  // ALU hookup
  logic [63:0] alu_a, alu_b, alu_sum;
  logic        alu_cin, alu_cout, alu_ovf, alu_lts, alu_ltu, alu_eq;
  // Software write strobes
  logic        apb_done, wr_ctrl, wr_xer;

  assign impl64 = ctrl_ff[ifd_pkg::CTRL_IMPL64_BIT];
  // A narrow implementation always runs narrow
  assign mode32 = ctrl_ff[ifd_pkg::CTRL_MODE32_BIT] | ~impl64;

  ifd_alu u_alu (
    .a_in      (alu_a),
    .b_in      (alu_b),
    .cin_in    (alu_cin),
    .mode32_in (mode32),
    .sum_out   (alu_sum),
    .cout_out  (alu_cout),
    .ovf_out   (alu_ovf),
    .lt_s_out  (alu_lts),
    .lt_u_out  (alu_ltu),
    .eq_out    (alu_eq)
  );

  // Field extraction and form selection
  always_comb begin
    primary_opcode     = 6'(be_field(insn_in, ifd_pkg::PRIMARY_OPCODE_FIRST,
                           ifd_pkg::PRIMARY_OPCODE_LAST));
    base_sel = 5'(be_field(insn_in, ifd_pkg::RA_FIRST, ifd_pkg::RA_LAST));
    targ_sel = 5'(be_field(insn_in, ifd_pkg::TO_FIRST, ifd_pkg::TO_LAST));
    imm16    = 16'(be_field(insn_in, ifd_pkg::IMM_FIRST,
                            ifd_pkg::IMM_LAST));
    unsigned_immediate_ext = {48'h0, imm16};
    simm_ext = {{48{imm16[15]}}, imm16};
    xo9      = 9'(be_field(insn_in, 22, 30));
    oe       = 1'(be_field(insn_in, ifd_pkg::OE_BIT, ifd_pkg::OE_BIT));
    rc       = 1'(be_field(insn_in, ifd_pkg::RC_BIT, ifd_pkg::RC_BIT));
    // Register zero in base position reads as zero
    base_val = (base_sel == 5'h00) ? 64'h0 : gpr_a_data_in;
    arith    = 1'b0;
    case (xo9)
      ifd_pkg::XO_ADD, ifd_pkg::XO_ADDC, ifd_pkg::XO_ADDE,
      ifd_pkg::XO_SUBF, ifd_pkg::XO_SUBFC, ifd_pkg::XO_SUBFE,
      ifd_pkg::XO_NEG: begin
        arith = 1'b1;
      end
      default: begin
        arith = 1'b0;
      end
    endcase
    // Form follows the primary opcode
    case (primary_opcode)
      ifd_pkg::OP_CROPS: form = ifd_pkg::XO_21_30;
      ifd_pkg::OP_EXT: begin
        if (9'(be_field(insn_in, 21, 29)) == ifd_pkg::XO_SRADI) begin
          form = ifd_pkg::XO_21_29;
        end else if (arith) begin
          form = ifd_pkg::XO_22_30;
        end else begin
          form = ifd_pkg::XO_21_30;
        end
      end
      ifd_pkg::OP_ROT64: begin
        // Bit 27 splits the short and long rotate forms
        form = be_field(insn_in, 27, 27) != 32'h0 ? ifd_pkg::XO_27_30
                                                  : ifd_pkg::XO_27_29;
      end
      ifd_pkg::OP_DSLD, ifd_pkg::OP_DSST: form = ifd_pkg::XO_30_31;
      ifd_pkg::OP_FP: form = ifd_pkg::XO_26_30;
      default: form = ifd_pkg::XO_NONE;
    endcase
    case (form)
      ifd_pkg::XO_21_29: nxt_xo = 10'(be_field(insn_in, 21, 29));
      ifd_pkg::XO_21_30: nxt_xo = 10'(be_field(insn_in, 21, 30));
      ifd_pkg::XO_22_30: nxt_xo = 10'(be_field(insn_in, 22, 30));
      ifd_pkg::XO_26_30: nxt_xo = 10'(be_field(insn_in, 26, 30));
      ifd_pkg::XO_27_29: nxt_xo = 10'(be_field(insn_in, 27, 29));
      ifd_pkg::XO_27_30: nxt_xo = 10'(be_field(insn_in, 27, 30));
      ifd_pkg::XO_30_31: nxt_xo = 10'(be_field(insn_in, 30, 31));
      default:           nxt_xo = 10'h000;
    endcase
    nxt_xo_form = form;
    // Wide-only forms refused on a narrow implementation
    nxt_illegal = insn_valid_in & ~impl64 &
                  (form == ifd_pkg::XO_21_29 || form == ifd_pkg::XO_27_29 ||
                   form == ifd_pkg::XO_27_30 || form == ifd_pkg::XO_30_31);
    exec          = insn_valid_in & ~nxt_illegal;
    nxt_trap_cond = targ_sel;
    nxt_trap_en   = exec & (primary_opcode == ifd_pkg::OP_TWI ||
                    (primary_opcode == ifd_pkg::OP_EXT && nxt_xo == ifd_pkg::XO_TW));
    nxt_unsigned_immediate_ext  = unsigned_immediate_ext;
  end

  // Execution, flags, condition fields and fetch target
  always_comb begin
    alu_a      = gpr_a_data_in;
    alu_b      = gpr_b_data_in;
    alu_cin    = 1'b0;
    nxt_result = result_ff;
    nxt_wr_en  = 1'b0;
    nxt_wr_sel = targ_sel;
    nxt_xer    = xer_ff;
    nxt_cr     = cr_ff;
    // Software writes first, so hardware updates below win
    if (wr_xer) begin
      nxt_xer = pwdata_in[2:0];
    end
    if (exec && primary_opcode == ifd_pkg::OP_EXT && arith) begin
      // Subtracts invert the first operand and add one, or the carry for the extended subtract
      if (xo9 == ifd_pkg::XO_SUBF || xo9 == ifd_pkg::XO_SUBFC ||
          xo9 == ifd_pkg::XO_NEG) begin
        alu_a   = ~gpr_a_data_in;
        alu_cin = 1'b1;
      end else if (xo9 == ifd_pkg::XO_SUBFE) begin
        alu_a   = ~gpr_a_data_in;
        alu_cin = xer_ff[ifd_pkg::XER_CA_BIT];
      end else if (xo9 == ifd_pkg::XO_ADDE) begin
        alu_cin = xer_ff[ifd_pkg::XER_CA_BIT];
      end
      if (xo9 == ifd_pkg::XO_NEG) begin
        alu_b = 64'h0;
      end
      nxt_result = alu_sum;
      nxt_wr_en  = 1'b1;
      // Carry and extended variants record carry
      if (xo9 != ifd_pkg::XO_ADD && xo9 != ifd_pkg::XO_SUBF &&
          xo9 != ifd_pkg::XO_NEG) begin
        nxt_xer[ifd_pkg::XER_CA_BIT] = alu_cout;
      end
      // Overflow-recording variants
      if (oe) begin
        nxt_xer[ifd_pkg::XER_OV_BIT] = alu_ovf;
        nxt_xer[ifd_pkg::XER_SO_BIT] = nxt_xer[ifd_pkg::XER_SO_BIT] |
                                       alu_ovf;
      end
    end else if (exec && primary_opcode == ifd_pkg::OP_ADDI) begin
      alu_a      = base_val;
      alu_b      = simm_ext;
      nxt_result = alu_sum;
      nxt_wr_en  = 1'b1;
    end else if (exec && primary_opcode == ifd_pkg::OP_ORI) begin
      nxt_result = gpr_s_data_in | unsigned_immediate_ext;
      nxt_wr_en  = 1'b1;
      nxt_wr_sel = base_sel;
    end else if (exec && primary_opcode == ifd_pkg::OP_ANDI) begin
      nxt_result = gpr_s_data_in & unsigned_immediate_ext;
      nxt_wr_en  = 1'b1;
      nxt_wr_sel = base_sel;
    end else if (exec && (primary_opcode == ifd_pkg::OP_CMPI ||
                          primary_opcode == ifd_pkg::OP_CMPLI)) begin
      // Signed against signed immediate, unsigned against unsigned
      alu_b = (primary_opcode == ifd_pkg::OP_CMPI) ? simm_ext : unsigned_immediate_ext;
      nxt_cr[7:4] = {(primary_opcode == ifd_pkg::OP_CMPI) ? alu_lts : alu_ltu,
                     (primary_opcode == ifd_pkg::OP_CMPI) ? ~alu_lts & ~alu_eq
                                                : ~alu_ltu & ~alu_eq,
                     alu_eq, xer_ff[ifd_pkg::XER_SO_BIT]};
    end
    // Record form of integer results, the and-immediate always records
    // Only the arithmetic group and the float opcode own a record bit; elsewhere bit 31 is data
    if (nxt_wr_en && ((rc && primary_opcode == ifd_pkg::OP_EXT) ||
                      primary_opcode == ifd_pkg::OP_ANDI)) begin
      if (mode32) begin
        nxt_cr[7] = nxt_result[31];
        nxt_cr[5] = nxt_result[31:0] == 32'h0;
      end else begin
        nxt_cr[7] = nxt_result[63];
        nxt_cr[5] = nxt_result == 64'h0;
      end
      nxt_cr[6] = ~nxt_cr[7] & ~nxt_cr[5];
      nxt_cr[4] = nxt_xer[ifd_pkg::XER_SO_BIT];
    end
    // Float record form carries the summary overflow
    if (exec && primary_opcode == ifd_pkg::OP_FP && rc) begin
      nxt_cr[3:0] = {3'h0, nxt_xer[ifd_pkg::XER_SO_BIT]};
    end
    // Next fetch: relative or absolute branch, else sequential
    if (exec && primary_opcode == ifd_pkg::OP_BRANCH) begin
      tgt = {{38{insn_in[25]}},
             24'(be_field(insn_in, ifd_pkg::LI_FIRST, ifd_pkg::LI_LAST)),
             2'h0};
      if (be_field(insn_in, ifd_pkg::AA_BIT, ifd_pkg::AA_BIT) == 32'h0) begin
        tgt = tgt + cia_in;
      end
    end else begin
      tgt = cia_in + ifd_pkg::INSN_STEP;
    end
    nxt_fetch   = mode32 ? {32'h0, tgt[31:0]} : tgt;
    nxt_fvalid  = exec;
    nxt_ill_cnt = ill_cnt_ff + {15'h0, nxt_illegal};
  end

  // APB answer one cycle into the access phase
  assign apb_done = psel_in & penable_in & pready_ff;
  assign wr_ctrl  = apb_done & pwrite_in & (paddr_in == ifd_pkg::ADDR_CTRL);
  assign wr_xer   = apb_done & pwrite_in & (paddr_in == ifd_pkg::ADDR_XER);

  // Slave next values; unmapped addresses answer with an error
  always_comb begin
    nxt_pready  = psel_in & penable_in & ~pready_ff;
    nxt_prdata  = 32'h0;
    nxt_pslverr = 1'b0;
    nxt_ctrl    = wr_ctrl ? pwdata_in[1:0] : ctrl_ff;
    if (nxt_pready) begin
      case (paddr_in)
        ifd_pkg::ADDR_CTRL: nxt_prdata = {30'h0, ctrl_ff};
        ifd_pkg::ADDR_XER:  nxt_prdata = {29'h0, xer_ff};
        ifd_pkg::ADDR_CR:   nxt_prdata = {24'h0, cr_ff};
        ifd_pkg::ADDR_STAT: nxt_prdata = {16'h0, ill_cnt_ff};
        default:            nxt_pslverr = 1'b1;
      endcase
    end
  end

  // State registers
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      trap_cond_ff <= 5'h00;
      trap_en_ff   <= 1'b0;
      unsigned_immediate_ext_ff  <= 64'h0;
      xo_ff        <= 10'h000;
      xo_form_ff   <= 3'h0;
      illegal_ff   <= 1'b0;
      result_ff    <= 64'h0;
      wr_en_ff     <= 1'b0;
      wr_sel_ff    <= 5'h00;
      fetch_ff     <= 64'h0;
      fvalid_ff    <= 1'b0;
      cr_ff        <= ifd_pkg::CR_RST;
      xer_ff       <= ifd_pkg::XER_RST;
      ill_cnt_ff   <= 16'h0000;
      ctrl_ff      <= ifd_pkg::CTRL_RST;
      prdata_ff    <= 32'h0;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
    end else begin
      trap_cond_ff <= nxt_trap_cond;
      trap_en_ff   <= nxt_trap_en;
      unsigned_immediate_ext_ff  <= nxt_unsigned_immediate_ext;
      xo_ff        <= nxt_xo;
      xo_form_ff   <= nxt_xo_form;
      illegal_ff   <= nxt_illegal;
      result_ff    <= nxt_result;
      wr_en_ff     <= nxt_wr_en;
      wr_sel_ff    <= nxt_wr_sel;
      fetch_ff     <= nxt_fetch;
      fvalid_ff    <= nxt_fvalid;
      cr_ff        <= nxt_cr;
      xer_ff       <= nxt_xer;
      ill_cnt_ff   <= nxt_ill_cnt;
      ctrl_ff      <= nxt_ctrl;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
    end
  end

  // Outputs straight from flip-flops
  assign trap_cond_out     = trap_cond_ff;
  assign trap_en_out       = trap_en_ff;
  assign unsigned_immediate_ext_out      = unsigned_immediate_ext_ff;
  assign xo_out            = xo_ff;
  assign xo_form_out       = xo_form_ff;
  assign illegal_out       = illegal_ff;
  assign result_out        = result_ff;
  assign gpr_wr_en_out     = wr_en_ff;
  assign gpr_wr_sel_out    = wr_sel_ff;
  assign next_fetch_out    = fetch_ff;
  assign fetch_valid_out   = fvalid_ff;
  assign cond_reg_out      = cr_ff;
  assign carry_flag_out    = xer_ff[ifd_pkg::XER_CA_BIT];
  assign overflow_flag_out = xer_ff[ifd_pkg::XER_OV_BIT];
  assign summary_ovf_out   = xer_ff[ifd_pkg::XER_SO_BIT];
  assign prdata_out        = prdata_ff;
  assign pready_out        = pready_ff;
  assign pslverr_out       = pslverr_ff;

endmodule

// ===== testbench/ifd_decode_assertions.sv
/*
  Port-level checks of the decoder: field extraction, APB answer, forms.
  Assumes a bind to ifd_decode and a single clock domain.
*/
`timescale 1ns/100ps
module ifd_decode_chk (
  // Clock, reset and APB
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pready_out,
  // Fetch side
  input wire logic        insn_valid_in,
  input wire logic [31:0] insn_in,
  input wire logic [63:0] cia_in,
  // Decoded outputs
  input wire logic [4:0]  trap_cond_out,
  input wire logic [63:0] unsigned_immediate_ext_out,
  input wire logic [9:0]  xo_out,
  input wire logic [2:0]  xo_form_out,
  input wire logic        illegal_out,
  input wire logic [63:0] result_out,
  input wire logic        gpr_wr_en_out,
  input wire logic [63:0] next_fetch_out,
  input wire logic        fetch_valid_out,
  input wire logic [7:0]  cond_reg_out
);
  // Reset edge is skipped through the past value of reset
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  trap_field_a: assert property ($past(arst_n_in) |->
    trap_cond_out == $past(insn_in[25:21])) else $error("trap field");
  unsigned_immediate_zext_a: assert property ($past(arst_n_in) |->
    unsigned_immediate_ext_out == {48'h0, $past(insn_in[15:0])}) else $error("unsigned_immediate");
  apb_answer_a: assert property (psel_in && penable_in && !pready_out
    |=> pready_out) else $error("pready late");
  fp_form_a: assert property (insn_valid_in &&
    insn_in[31:26] == ifd_pkg::OP_FP |=> xo_form_out == 3'h4 &&
    xo_out == {5'h0, $past(insn_in[5:1])}) else $error("fp form");
  illegal_quiet_a: assert property (illegal_out |->
    !fetch_valid_out && !gpr_wr_en_out) else $error("illegal wrote");
  no_record_a: assert property (insn_valid_in && !insn_in[0] &&
    insn_in[31:26] == ifd_pkg::OP_EXT |=> $stable(cond_reg_out))
    else $error("cond changed");
  base_zero_a: assert property (insn_valid_in &&
    insn_in[31:26] == ifd_pkg::OP_ADDI && insn_in[20:16] == 5'h0 |=>
    result_out[31:0] == {{16{$past(insn_in[15])}}, $past(insn_in[15:0])})
    else $error("base zero");
  seq_fetch_a: assert property (insn_valid_in &&
    insn_in[31:26] == ifd_pkg::OP_ORI |=> fetch_valid_out &&
    next_fetch_out[31:0] == $past(cia_in[31:0]) + 32'h4)
    else $error("next fetch");
endmodule

bind ifd_decode ifd_decode_chk u_chk (.*);

// ===== testbench/ifd_gpr_model.sv
/*
  Register file behind the operand ports, written back by the decoder.
  Assumes field bit 0 is word bit 31; register 0 starts unknown.
*/
`timescale 1ns/100ps
module ifd_gpr_model (
  // Clock and word on offer
  input  wire logic        clk_in,
  input  wire logic [31:0] insn_in,
  // Writeback and bench preload
  input  wire logic        wr_en_in,
  input  wire logic [4:0]  wr_sel_in,
  input  wire logic [63:0] wr_data_in,
  input  wire logic        ld_en_in,
  input  wire logic [4:0]  ld_sel_in,
  input  wire logic [63:0] ld_data_in,
  // Operand contents
  output logic [63:0]      a_out,
  output logic [63:0]      b_out,
  output logic [63:0]      s_out
);
  logic [63:0] rf [32];  // Unknown r0 exposes a missing zero substitute
  // Reads follow the fields at once
  assign a_out = rf[insn_in[20:16]];
  assign b_out = rf[insn_in[15:11]];
  assign s_out = rf[insn_in[25:21]];
  // Preload wins over writeback
  always @(posedge clk_in) begin
    if (ld_en_in)
      rf[ld_sel_in] <= ld_data_in;
    else if (wr_en_in)
      rf[wr_sel_in] <= wr_data_in;
  end
endmodule

// ===== testbench/insn_field_flag_decode_tb_top.sv
/*
  Bench: APB control, random arithmetic, mode and illegal-form corners.
  Assumes decode latency of one cycle and a three-cycle APB access.
*/
`timescale 1ns/100ps
module insn_field_flag_decode_tb_top;
  logic        ref_clk_in = 1'h0, arst_n_in = 1'h0;  // Clock, reset
  logic        psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic        pready_out, pslverr_out, er;
  logic        insn_valid_in = 1'h0, ld_en = 1'h0;
  logic [31:0] insn_in = 32'h0;
  logic [63:0] cia_in = 64'h0, ld_dat = 64'h0;
  logic [4:0]  ld_sel = 5'h0, trap_cond_out, gpr_wr_sel_out;
  logic [63:0] gpr_a_data_in, gpr_b_data_in, gpr_s_data_in;
  logic [63:0] unsigned_immediate_ext_out, result_out, next_fetch_out;
  logic [9:0]  xo_out;
  logic [2:0]  xo_form_out;
  logic [7:0]  cond_reg_out;
  logic        trap_en_out, illegal_out, gpr_wr_en_out, fetch_valid_out;
  logic        carry_flag_out, overflow_flag_out, summary_ovf_out;
  int          err_total = 0, total_checks = 0;

  always #4 ref_clk_in = ~ref_clk_in;  // 125 MHz
  ifd_decode dut (.*);
  ifd_gpr_model u_rf (.clk_in(ref_clk_in), .insn_in(insn_in),
    .wr_en_in(gpr_wr_en_out), .wr_sel_in(gpr_wr_sel_out),
    .wr_data_in(result_out), .ld_en_in(ld_en), .ld_sel_in(ld_sel),
    .ld_data_in(ld_dat), .a_out(gpr_a_data_in), .b_out(gpr_b_data_in),
    .s_out(gpr_s_data_in));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    psel_in   <= 1'h1;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    // A slave that never answers is a mismatch
    if (n >= 20)
      err_total++;
    rd = prdata_out;
    er = pslverr_out;
    psel_in    <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic load(input logic [4:0] s, input logic [63:0] v);
    @(posedge ref_clk_in);
    ld_en  <= 1'h1;
    ld_sel <= s;
    ld_dat <= v;
  endtask
  // One word for one cycle; outputs settle after the next edge
  task automatic issue(input logic [31:0] w, input logic [63:0] c);
    @(posedge ref_clk_in);
    ld_en         <= 1'h0;
    insn_valid_in <= 1'h1;
    insn_in       <= w;
    cia_in        <= c;
    @(posedge ref_clk_in);
    insn_valid_in <= 1'h0;
    #1;
  endtask
  function automatic logic [3:0] crf(input logic [63:0] v, input logic o);
    return {v[63], !v[63] && v != 64'h0, v == 64'h0, o};
  endfunction

  initial begin
    logic [63:0] a, b;
    logic [64:0] s;
    logic [3:0]  cr4;
    logic        ca, ov, so, oe, vf, rc;
    logic [8:0]  xo [3];
    logic [31:0] rst_exp [4];
    xo = '{ifd_pkg::XO_ADD, ifd_pkg::XO_ADDC, ifd_pkg::XO_ADDE};
    rst_exp = '{32'h2, 32'h0, 32'h0, 32'h0};
    {ca, ov, so, cr4} = 7'h00;
    void'($urandom(52136));
    repeat (3) @(posedge ref_clk_in);
    arst_n_in <= 1'h1;
    foreach (rst_exp[i]) begin
      apb(1'h0, 8'(i * 4), 32'h0);
      check(rd, rst_exp[i]);
    end
    apb(1'h0, 8'h10, 32'h0);
    check({er, rd}, 33'h1_0000_0000);  // Unmapped place
    // Add, carrying add, extended add; first one overflows
    for (int i = 0; i < 24; i++) begin
      oe = (i % 4 == 0);
      rc = (i % 5 != 4);
      a = (i == 0) ? 64'h7FFF_FFFF_FFFF_FFFF : {$urandom, $urandom};
      b = (i == 0) ? 64'h1 : {$urandom, $urandom};
      load(5'h1, a);
      load(5'h2, b);
      issue({6'h1F, 5'h3, 5'h1, 5'h2, oe, xo[i % 3], rc}, 64'h100);
      s = {1'h0, a} + {1'h0, b} + {64'h0, (i % 3 == 2) & ca};
      vf = (a[63] == b[63]) && (s[63] != a[63]);
      if (i % 3 != 0)
        ca = s[64];
      if (oe) begin
        ov = vf;
        so = so | vf;
      end
      if (rc)
        cr4 = crf(s[63:0], so);
      check(result_out, s[63:0]);
      check(gpr_wr_sel_out, 5'h3);
      check(carry_flag_out, ca);
      check({overflow_flag_out, summary_ovf_out}, {ov, so});
      check(cond_reg_out[7:4], cr4);
    end
    // Wide then 32-bit mode fetch address
    for (int m = 0; m < 2; m++) begin
      apb(1'h1, ifd_pkg::ADDR_CTRL, 32'h2 | m);
      a = {$urandom, $urandom};
      issue({ifd_pkg::OP_ORI, 5'h4, 5'h5, 16'hBEEF}, a);
      b = a + ifd_pkg::INSN_STEP;
      check(next_fetch_out, m ? {32'h0, b[31:0]} : b);
      check(unsigned_immediate_ext_out, 64'hBEEF);
    end
    issue({ifd_pkg::OP_ADDI, 5'h6, 5'h0, 16'h8001}, 64'h0);
    check(result_out, 64'hFFFF_FFFF_FFFF_8001);
    check(cond_reg_out[7:4], cr4);
    issue({ifd_pkg::OP_FP, 20'h0, 5'h12, 1'h1}, 64'h0);
    check(cond_reg_out[3:0], {3'h0, so});
    apb(1'h1, ifd_pkg::ADDR_CTRL, 32'h0);  // Narrow implementation
    issue({ifd_pkg::OP_DSLD, 24'h0, 2'h1}, 64'h0);
    check({illegal_out, fetch_valid_out}, 2'h2);
    issue({ifd_pkg::OP_TWI, 5'h15, 21'h0}, 64'h0);
    check({trap_en_out, trap_cond_out}, 6'h35);
    apb(1'h0, ifd_pkg::ADDR_STAT, 32'h0);
    check(rd, 32'h1);
    final_report();
  end

  // Watchdog far beyond the roughly 150 cycles the tests need
  initial begin
    #100000;
    err_total++;
    final_report();
  end
endmodule
